// *** hdl/vfp_consts.svh ***
// Register map, reset values and timing counts of the video black-level and format path.
// Assumes inclusion by bare name from the package and the design module.
`ifndef VFP_CONSTS_SVH
`define VFP_CONSTS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define VFP_IDX_INPUT_CFG 8'h10
`define VFP_IDX_GAIN_HI_A 8'h12
`define VFP_IDX_GAIN_LO_A 8'h13
`define VFP_IDX_GAIN_HI_B 8'h14
`define VFP_IDX_GAIN_LO_B 8'h15
`define VFP_IDX_GAIN_HI_C 8'h16
`define VFP_IDX_GAIN_LO_C 8'h17
`define VFP_IDX_OFFSET_A 8'h18
`define VFP_IDX_OFFSET_B 8'h19
`define VFP_IDX_OFFSET_C 8'h1a
`define VFP_IDX_DAC_A 8'h1c
`define VFP_IDX_DAC_B 8'h1d
`define VFP_IDX_DAC_C 8'h1e
`define VFP_IDX_FORMAT_CFG 8'h28
`define VFP_IDX_FRONT_CTRL 8'h60

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VFP_BIT_BLACK_LOOP_EN 0
`define VFP_BIT_COMPONENT 4
`define VFP_BIT_DECIMATE 0
`define VFP_BIT_CONV_EN 6
`define VFP_BIT_MID_BLUE 4
`define VFP_BIT_MID_GREEN 5
`define VFP_BIT_MID_RED 6
`define VFP_BIT_MID_OVERRIDE 7

// ----------------------------------------------------------------
// Reset values and levels
// ----------------------------------------------------------------
`define VFP_INPUT_CFG_RST 8'h01
`define VFP_GAIN_HI_RST 8'h55
`define VFP_GAIN_LO_RST 2'h0
`define VFP_OFFSET_NOMINAL 10'h200
`define VFP_FORMAT_CFG_RST 8'h00
`define VFP_FRONT_CTRL_RST 8'h00
`define VFP_MIDSCALE 10'h200
`define VFP_OFFSET_RANGE 10'd64
`define VFP_CODE_MAX 10'h3ff

// ----------------------------------------------------------------
// Colour conversion weights, scaled by 1024
// ----------------------------------------------------------------
`define VFP_K_Y_R 12'sd306
`define VFP_K_Y_G 12'sd601
`define VFP_K_Y_B 12'sd117
`define VFP_K_U_R -12'sd176
`define VFP_K_U_G -12'sd347
`define VFP_K_U_B 12'sd523
`define VFP_K_V_R 12'sd523
`define VFP_K_V_G -12'sd438
`define VFP_K_V_B -12'sd85
`define VFP_CHROMA_BIAS 10'd512

// Back-porch samples between two black-level steps
`define VFP_BLACK_UPDATE_SAMPLES 1024

`endif

// *** hdl/vfp_pkg.sv ***
// Types shared by the video black-level and format path.
// Assumes vfp_consts.svh is on the include path.
`include "vfp_consts.svh"

package vfp_pkg;

	typedef logic [2:0][9:0] vfp_chan10_t;

	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic [7:0] input_cfg;
		logic [2:0][7:0] gain_hi;
		logic [2:0][1:0] gain_lo;
		vfp_chan10_t offset;
		vfp_chan10_t dac;
		logic [7:0] format_cfg;
		logic [7:0] front_ctrl;
		logic [15:0] upd_cnt;
		logic phase;
		logic [9:0] v_hold;
		vfp_chan10_t pix;
		logic pix_valid;
	} vfp_state_t;

endpackage : vfp_pkg

// *** hdl/vfp_black_format.sv ***
// Black-level loop, gain/offset registers and output formatter of a three-channel video digitizer.
// Assumes converter samples and the back-porch window arrive synchronous to clk_in.
`timescale 1ns/1ns
`default_nettype none
`include "vfp_consts.svh"

module vfp_black_format #(
	parameter int UPDATE_SAMPLES = `VFP_BLACK_UPDATE_SAMPLES
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [9:0] address_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic [3:0] byteenable_in,
	input wire logic [31:0] writedata_in,
	output logic [31:0] readdata_out,
	output logic waitrequest_out,
	input wire logic [9:0] red_sample_in,
	input wire logic [9:0] green_sample_in,
	input wire logic [9:0] blue_sample_in,
	input wire logic sample_valid_in,
	input wire logic back_porch_in,
	output logic [9:0] red_dac_out,
	output logic [9:0] green_dac_out,
	output logic [9:0] blue_dac_out,
	output logic [9:0] red_gain_out,
	output logic [9:0] green_gain_out,
	output logic [9:0] blue_gain_out,
	output logic [2:0] midscale_out,
	output logic [9:0] red_bus_out,
	output logic [9:0] green_bus_out,
	output logic [9:0] blue_bus_out,
	output logic pixel_valid_out
);

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------

	// Weighted sum with rounding, bias and clipping
	function automatic logic [9:0] vfp_mac(
		input logic signed [11:0] ka,
		input logic signed [11:0] kb,
		input logic signed [11:0] kc,
		input logic [9:0] a,
		input logic [9:0] b,
		input logic [9:0] c,
		input logic [9:0] bias
	);
		logic signed [24:0] acc;
		acc = 25'(ka * $signed({1'b0, a})) + 25'(kb * $signed({1'b0, b}))
			+ 25'(kc * $signed({1'b0, c})) + 25'sd512
			+ $signed(25'({bias, 10'h000}));
		if (acc < 0) begin
			vfp_mac = 10'h000;
		end else if (acc[24:10] > 15'(`VFP_CODE_MAX)) begin
			vfp_mac = `VFP_CODE_MAX;
		end else begin
			vfp_mac = acc[19:10];
		end
	endfunction : vfp_mac

	// Sample above target lowers the DAC, below raises it; saturates at both ends
	function automatic logic [9:0] vfp_step_dac(input logic [9:0] dac, input logic [9:0] smp, input logic signed [11:0] tgt);
		logic [9:0] d;
		d = dac;
		if ($signed({2'b00, smp}) > tgt && dac != 10'h000) begin
			d = dac - 10'h001;
		end else if ($signed({2'b00, smp}) < tgt && dac != `VFP_CODE_MAX) begin
			d = dac + 10'h001;
		end
		vfp_step_dac = d;
	endfunction : vfp_step_dac

	// Register read decode
	function automatic logic [31:0] vfp_read(input vfp_pkg::vfp_state_t st, input logic [7:0] idx);
		logic [31:0] d;
		d = 32'h0000_0000;
		unique case (idx)
			`VFP_IDX_INPUT_CFG: d = {24'h000000, st.input_cfg};
			`VFP_IDX_GAIN_HI_A: d = {24'h000000, st.gain_hi[0]};
			`VFP_IDX_GAIN_LO_A: d = {30'h0, st.gain_lo[0]};
			`VFP_IDX_GAIN_HI_B: d = {24'h000000, st.gain_hi[1]};
			`VFP_IDX_GAIN_LO_B: d = {30'h0, st.gain_lo[1]};
			`VFP_IDX_GAIN_HI_C: d = {24'h000000, st.gain_hi[2]};
			`VFP_IDX_GAIN_LO_C: d = {30'h0, st.gain_lo[2]};
			`VFP_IDX_OFFSET_A: d = {22'h0, st.offset[0]};
			`VFP_IDX_OFFSET_B: d = {22'h0, st.offset[1]};
			`VFP_IDX_OFFSET_C: d = {22'h0, st.offset[2]};
			`VFP_IDX_DAC_A: d = {22'h0, st.dac[0]};
			`VFP_IDX_DAC_B: d = {22'h0, st.dac[1]};
			`VFP_IDX_DAC_C: d = {22'h0, st.dac[2]};
			`VFP_IDX_FORMAT_CFG: d = {24'h000000, st.format_cfg};
			`VFP_IDX_FRONT_CTRL: d = {24'h000000, st.front_ctrl};
			default: d = 32'h0000_0000;
		endcase
		vfp_read = d;
	endfunction : vfp_read

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	vfp_pkg::vfp_state_t s;
	vfp_pkg::vfp_state_t next_s;
	vfp_pkg::vfp_chan10_t sample;
	logic [2:0] mid;
	logic component;
	logic loop_en;
	logic yuv_out;
	logic [9:0] conv_y;
	logic [9:0] conv_u;
	logic [9:0] conv_v;
	logic [9:0] y_val;
	logic [9:0] u_val;
	logic [9:0] v_val;
	logic [7:0] idx;

	assign sample = {blue_sample_in, green_sample_in, red_sample_in};
	assign idx = address_in[9:2];
	assign component = s.input_cfg[`VFP_BIT_COMPONENT];
	assign loop_en = s.input_cfg[`VFP_BIT_BLACK_LOOP_EN];

	// ----------------------------------------------------------------
	// Mid-scale selection and colour conversion
	// ----------------------------------------------------------------
	always_comb begin
		if (s.front_ctrl[`VFP_BIT_MID_OVERRIDE]) begin
			mid = {~s.front_ctrl[`VFP_BIT_MID_BLUE], ~s.front_ctrl[`VFP_BIT_MID_GREEN],
				~s.front_ctrl[`VFP_BIT_MID_RED]};
		end else begin
			mid = {component, 1'b0, component};
		end
	end

	assign conv_y = vfp_mac(`VFP_K_Y_R, `VFP_K_Y_G, `VFP_K_Y_B, red_sample_in, green_sample_in,
		blue_sample_in, 10'h000);
	assign conv_u = vfp_mac(`VFP_K_U_R, `VFP_K_U_G, `VFP_K_U_B, red_sample_in, green_sample_in,
		blue_sample_in, `VFP_CHROMA_BIAS);
	assign conv_v = vfp_mac(`VFP_K_V_R, `VFP_K_V_G, `VFP_K_V_B, red_sample_in, green_sample_in,
		blue_sample_in, `VFP_CHROMA_BIAS);

	always_comb begin
		yuv_out = component | s.format_cfg[`VFP_BIT_CONV_EN];
		if (!component && s.format_cfg[`VFP_BIT_CONV_EN]) begin
			y_val = conv_y;
			u_val = conv_u;
			v_val = conv_v;
		end else begin
			y_val = green_sample_in;
			u_val = blue_sample_in;
			v_val = red_sample_in;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic signed [11:0] shift;
		logic signed [11:0] target;
		logic step;
		shift = 12'sd0;
		target = 12'sd0;
		step = 1'b0;
		next_s = s;

		// Bus slave: one wait state, then the access completes
		next_s.ack = (read_in | write_in) & ~s.ack;
		// Read data captured on the request edge, stands through the answer
		if (read_in && !s.ack) begin
			next_s.rdata = vfp_read(s, idx);
		end
		if (write_in && s.ack && byteenable_in[0]) begin
			unique case (idx)
				`VFP_IDX_INPUT_CFG: next_s.input_cfg = writedata_in[7:0];
				`VFP_IDX_GAIN_HI_A: next_s.gain_hi[0] = writedata_in[7:0];
				`VFP_IDX_GAIN_LO_A: next_s.gain_lo[0] = writedata_in[1:0];
				`VFP_IDX_GAIN_HI_B: next_s.gain_hi[1] = writedata_in[7:0];
				`VFP_IDX_GAIN_LO_B: next_s.gain_lo[1] = writedata_in[1:0];
				`VFP_IDX_GAIN_HI_C: next_s.gain_hi[2] = writedata_in[7:0];
				`VFP_IDX_GAIN_LO_C: next_s.gain_lo[2] = writedata_in[1:0];
				`VFP_IDX_OFFSET_A: next_s.offset[0][7:0] = writedata_in[7:0];
				`VFP_IDX_OFFSET_B: next_s.offset[1][7:0] = writedata_in[7:0];
				`VFP_IDX_OFFSET_C: next_s.offset[2][7:0] = writedata_in[7:0];
				`VFP_IDX_FORMAT_CFG: next_s.format_cfg = writedata_in[7:0];
				`VFP_IDX_FRONT_CTRL: next_s.front_ctrl = writedata_in[7:0];
				default: next_s.ack = 1'b0;
			endcase
		end
		if (write_in && s.ack && byteenable_in[1]) begin
			unique case (idx)
				`VFP_IDX_OFFSET_A: next_s.offset[0][9:8] = writedata_in[9:8];
				`VFP_IDX_OFFSET_B: next_s.offset[1][9:8] = writedata_in[9:8];
				`VFP_IDX_OFFSET_C: next_s.offset[2][9:8] = writedata_in[9:8];
				default: next_s.ack = 1'b0;
			endcase
		end

		// Black-level loop: slow, one code per update
		if (sample_valid_in && back_porch_in) begin
			step = (s.upd_cnt == 16'(UPDATE_SAMPLES - 1));
			next_s.upd_cnt = step ? 16'h0000 : s.upd_cnt + 16'h0001;
		end
		for (int ch = 0; ch < 3; ch++) begin
			shift = $signed({2'b00, s.offset[ch]}) - $signed({2'b00, `VFP_OFFSET_NOMINAL});
			if (shift > $signed({2'b00, `VFP_OFFSET_RANGE})) begin
				shift = $signed({2'b00, `VFP_OFFSET_RANGE});
			end else if (shift < -$signed({2'b00, `VFP_OFFSET_RANGE})) begin
				shift = -$signed({2'b00, `VFP_OFFSET_RANGE});
			end
			target = (mid[ch] ? $signed({2'b00, `VFP_MIDSCALE}) : 12'sd0) + shift;
			if (!loop_en) begin
				next_s.dac[ch] = s.offset[ch];
			end else if (step) begin
				next_s.dac[ch] = vfp_step_dac(s.dac[ch], sample[ch], target);
			end
		end

		// Output formatter
		next_s.pix_valid = sample_valid_in;
		// Back porch realigns the chroma pairing for each line; in decimating YUV output a valid sample there still toggles the phase
		if (back_porch_in) begin
			next_s.phase = 1'b0;
		end
		if (sample_valid_in) begin
			if (!yuv_out) begin
				next_s.pix = sample;
			end else if (s.format_cfg[`VFP_BIT_DECIMATE]) begin
				next_s.pix[1] = y_val;
				next_s.pix[2] = 10'h000;
				next_s.pix[0] = s.phase ? s.v_hold : u_val;
				if (!s.phase) begin
					next_s.v_hold = v_val;
				end
				next_s.phase = ~s.phase;
			end else begin
				next_s.pix = {u_val, y_val, v_val};
			end
		end
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			// Fields not listed here reset to zero
			s <= '0;
			s.input_cfg <= `VFP_INPUT_CFG_RST;
			s.gain_hi <= {3{`VFP_GAIN_HI_RST}};
			s.gain_lo <= {3{`VFP_GAIN_LO_RST}};
			s.offset <= {3{`VFP_OFFSET_NOMINAL}};
			s.dac <= {3{`VFP_OFFSET_NOMINAL}};
			s.format_cfg <= `VFP_FORMAT_CFG_RST;
			s.front_ctrl <= `VFP_FRONT_CTRL_RST;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign waitrequest_out = (read_in | write_in) & ~s.ack;
	assign readdata_out = s.rdata;
	// Gain drives only the amplifier, never the DAC path
	assign red_gain_out = {s.gain_hi[0], s.gain_lo[0]};
	assign green_gain_out = {s.gain_hi[1], s.gain_lo[1]};
	assign blue_gain_out = {s.gain_hi[2], s.gain_lo[2]};
	assign red_dac_out = s.dac[0];
	assign green_dac_out = s.dac[1];
	assign blue_dac_out = s.dac[2];
	// Pin view {blue, green, red}: 1 = no half-scale shift added, black at zero
	assign midscale_out = ~mid;
	assign red_bus_out = s.pix[0];
	assign green_bus_out = s.pix[1];
	assign blue_bus_out = s.pix[2];
	assign pixel_valid_out = s.pix_valid;

endmodule : vfp_black_format

`default_nettype wire

// *** sim/vfp_black_format_assertions.sv ***
// Port checker of the black-level and format path.
// Assumes binding to vfp_black_format; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module vfp_black_format_assertions #(
	parameter int UPDATE_SAMPLES = 4
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic read_in,
	input wire logic write_in,
	input wire logic sample_valid_in,
	input wire logic back_porch_in,
	input wire logic waitrequest_out,
	input wire logic [9:0] red_dac_out,
	input wire logic [9:0] green_dac_out,
	input wire logic [9:0] blue_dac_out,
	input wire logic [9:0] red_gain_out,
	input wire logic [9:0] green_gain_out,
	input wire logic [9:0] red_bus_out,
	input wire logic [9:0] blue_bus_out,
	input wire logic pixel_valid_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);
	logic [29:0] dacs;
	assign dacs = {red_dac_out, green_dac_out, blue_dac_out};
	property p_valid_delay; 1'b1 |=> pixel_valid_out == $past(sample_valid_in); endproperty
	property p_wait_one; $rose(read_in || write_in) |-> waitrequest_out ##1 !waitrequest_out; endproperty
	property p_wait_short; waitrequest_out |=> !waitrequest_out; endproperty
	// Loop steps only after a black sample, by one code
	property p_red_step;
		$changed(red_dac_out) && !$past(write_in) && !$past(write_in, 2) && !$past(write_in, 3) |->
			$past(back_porch_in) && (red_dac_out - $past(red_dac_out) == 10'h1 || $past(red_dac_out) - red_dac_out == 10'h1);
	endproperty
	property p_dac_quiet; (!write_in && !back_porch_in) [*3] |=> $stable(dacs); endproperty
	property p_gain_cause; $changed({red_gain_out, green_gain_out}) |-> $past(write_in) || $past(write_in, 2); endproperty
	property p_gain_keep; $changed(green_gain_out) && !$past(back_porch_in) |-> $stable(dacs); endproperty
	property p_bus_hold; !$past(sample_valid_in) |-> $stable({red_bus_out, blue_bus_out}); endproperty
	a_valid_delay: assert property (p_valid_delay) else $error("pixel valid delay wrong");
	a_wait_one: assert property (p_wait_one) else $error("wait state count wrong");
	a_wait_short: assert property (p_wait_short) else $error("wait held too long");
	a_red_step: assert property (p_red_step) else $error("offset step wrong");
	a_dac_quiet: assert property (p_dac_quiet) else $error("offset moved without cause");
	a_gain_cause: assert property (p_gain_cause) else $error("gain moved without write");
	a_gain_keep: assert property (p_gain_keep) else $error("gain write moved offset");
	a_bus_hold: assert property (p_bus_hold) else $error("bus moved without sample");
	c_loop: cover property ($changed(red_dac_out) && $past(back_porch_in));
	c_read: cover property (read_in && !waitrequest_out);
	c_pixel: cover property (pixel_valid_out ##1 pixel_valid_out);
endmodule : vfp_black_format_assertions
bind vfp_black_format vfp_black_format_assertions #(.UPDATE_SAMPLES(UPDATE_SAMPLES)) u_vfp_black_format_assertions (
	.clk_in, .rst_in, .read_in, .write_in, .sample_valid_in, .back_porch_in, .waitrequest_out, .red_dac_out,
	.green_dac_out, .blue_dac_out, .red_gain_out, .green_gain_out, .red_bus_out, .blue_bus_out, .pixel_valid_out
);
`default_nettype wire

// *** sim/vfp_pixel_sink.sv ***
// Downstream pixel consumer model.
// Assumes buses are meaningful only while valid_in is high.
`timescale 1ns/1ns
`default_nettype none
module vfp_pixel_sink (
	input wire logic clk_in,
	input wire logic [9:0] red_in,
	input wire logic [9:0] green_in,
	input wire logic [9:0] blue_in,
	input wire logic valid_in,
	output logic [29:0] pixel_out,
	output logic strobe_out
);
	always_ff @(posedge clk_in) begin
		strobe_out <= valid_in;
		if (valid_in) begin
			pixel_out <= {red_in, green_in, blue_in};
		end
	end
endmodule : vfp_pixel_sink
`default_nettype wire

// *** sim/tb_vfp_black_format.sv ***
// Self-checking bench of the black-level and format path.
// Assumes design, checker and pixel sink are compiled first.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) check_val(32'(g), 32'(e))
module tb_vfp_black_format;
	localparam int NS = 4;
	logic clk_in, rst_in, read_in, write_in, sample_valid_in, back_porch_in, waitrequest_out, pixel_valid_out, stb;
	logic [9:0] address_in, r_in, g_in, b_in, red_dac_out, green_dac_out, blue_dac_out, vh;
	logic [9:0] red_gain_out, green_gain_out, blue_gain_out, red_bus_out, green_bus_out, blue_bus_out;
	logic [3:0] byteenable_in;
	logic [31:0] writedata_in, readdata_out;
	logic [2:0] midscale_out;
	logic [29:0] pix;
	logic [31:0] rd_q[$];
	logic [29:0] px_q[$];
	int err_total, comparisons;
	bit comp, conv, dec, ph;
	vfp_black_format #(.UPDATE_SAMPLES(NS)) u_vfp_black_format (.clk_in, .rst_in, .address_in, .read_in, .write_in,
		.byteenable_in, .writedata_in, .readdata_out, .waitrequest_out, .red_sample_in(r_in), .green_sample_in(g_in),
		.blue_sample_in(b_in), .sample_valid_in, .back_porch_in, .red_dac_out, .green_dac_out, .blue_dac_out,
		.red_gain_out, .green_gain_out, .blue_gain_out, .midscale_out, .red_bus_out, .green_bus_out, .blue_bus_out,
		.pixel_valid_out);
	vfp_pixel_sink u_vfp_pixel_sink (.clk_in, .red_in(red_bus_out), .green_in(green_bus_out), .blue_in(blue_bus_out),
		.valid_in(pixel_valid_out), .pixel_out(pix), .strobe_out(stb));
	task automatic check_val(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : check_val
	task automatic complete_run();
		$display("comparisons=%0d err_total=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : complete_run
	// Avalon cycle, held until waitrequest seen low at a rising edge, released at that edge
	task automatic bus(input bit wr, input logic [7:0] idx, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		read_in <= !wr;
		write_in <= wr;
		address_in <= {idx, 2'b00};
		writedata_in <= d;
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (waitrequest_out !== 1'b0 && n < 100);
		if (waitrequest_out !== 1'b0) begin
			`CHK(0, 1);
			complete_run();
		end
		read_in <= 1'b0;
		write_in <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] idx, input logic [31:0] e);
		rd_q.push_back(e);
		bus(0, idx, 32'h0);
	endtask : rd
	function automatic int clip(input int x);
		return x < 0 ? 0 : (x > 1023 ? 1023 : x);
	endfunction : clip
	// Expected bus triple for the current mode
	function automatic logic [29:0] model(input int r, input int g, input int b);
		logic [9:0] rr, gg, bb;
		rr = 10'(r);
		gg = 10'(g);
		bb = 10'(b);
		if (conv && !comp) begin
			gg = 10'(clip((306 * r + 601 * g + 117 * b + 512) >>> 10));
			bb = 10'(clip((-176 * r - 347 * g + 523 * b + 524800) >>> 10));
			rr = 10'(clip((523 * r - 438 * g - 85 * b + 524800) >>> 10));
		end
		if ((conv || comp) && dec) begin
			if (!ph) begin
				vh = rr;
				rr = bb;
			end else begin
				rr = vh;
			end
			bb = 10'h0;
		end
		ph = !ph;
		return {rr, gg, bb};
	endfunction : model
	task automatic px(input logic [9:0] r, input logic [9:0] g, input logic [9:0] b, input bit bp, input bit v);
		@(posedge clk_in);
		r_in <= r;
		g_in <= g;
		b_in <= b;
		back_porch_in <= bp;
		sample_valid_in <= v;
		if (bp) ph = 0;
		if (v) px_q.push_back(model(r, g, b));
	endtask : px
	task automatic idle(input int n);
		repeat (n) px(10'h0, 10'h0, 10'h0, 0, 0);
		@(negedge clk_in);
	endtask : idle
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// Read data taken at the rising edge that ends the wait state
	always @(posedge clk_in) begin
		if (read_in === 1'b1 && waitrequest_out === 1'b0) `CHK(readdata_out, rd_q.pop_front());
	end
	always @(negedge clk_in) begin
		if (stb === 1'b1) `CHK(pix, px_q.pop_front());
	end
	initial begin
		logic [7:0] gh;
		logic [9:0] off;
		rst_in = 1'b1;
		{read_in, write_in, sample_valid_in, back_porch_in, comp, conv, dec, ph} = '0;
		{address_in, writedata_in, r_in, g_in, b_in, vh} = '0;
		byteenable_in = 4'hf;
		err_total = 0;
		comparisons = 0;
		void'($urandom(32'h6a0a7997));
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		rd(8'h12, 32'h55);
		rd(8'h13, 32'h0);
		rd(8'h10, 32'h1);
		rd(8'h18, 32'h200);
		rd(8'h1c, 32'h200);
		rd(8'h7f, 32'h0);
		`CHK(blue_gain_out, 10'h154);
		`CHK(midscale_out, 3'h7);
		repeat (NS) px(10'h5, 10'h0, 10'h0, 1, 1);
		idle(2);
		`CHK({red_dac_out, green_dac_out, blue_dac_out}, {10'h1ff, 10'h200, 10'h200});
		bus(1, 8'h10, 32'h11);
		comp = 1;
		idle(1);
		`CHK(midscale_out, 3'h2);
		repeat (NS) px(10'h1f0, 10'h3, 10'h200, 1, 1);
		idle(2);
		`CHK({red_dac_out, green_dac_out, blue_dac_out}, {10'h200, 10'h1ff, 10'h200});
		bus(1, 8'h60, 32'hc0);
		idle(1);
		`CHK(midscale_out, 3'h1);
		bus(1, 8'h60, 32'h0);
		gh = 8'($urandom);
		off = 10'($urandom_range(10'h240, 10'h1c0));
		bus(1, 8'h14, {24'h0, gh});
		bus(1, 8'h15, 32'h3);
		idle(2);
		`CHK(green_gain_out, {gh, 2'h3});
		`CHK(green_dac_out, 10'h1ff);
		bus(1, 8'h10, 32'h0);
		comp = 0;
		bus(1, 8'h18, {22'h0, off});
		idle(2);
		`CHK(red_dac_out, off);
		bus(1, 8'h1c, 32'h5);
		rd(8'h1c, {22'h0, off});
		for (int m = 0; m < 8; m++) begin
			{comp, conv, dec} = 3'(m);
			bus(1, 8'h10, {27'h0, comp, 4'h0});
			bus(1, 8'h28, {25'h0, conv, 5'h0, dec});
			px(10'h0, 10'h0, 10'h0, 1, 0);
			for (int k = 0; k < 6; k++) px(10'($urandom), 10'($urandom), 10'($urandom), 0, 1);
			px(10'h3ff, 10'h0, 10'h0, 0, 1);
			px(10'h3ff, 10'h3ff, 10'h0, 0, 1);
			idle(3);
		end
		complete_run();
	end
endmodule : tb_vfp_black_format
`default_nettype wire
